// ---- logic/bdr_receiver.sv ----
// receiver end: per-line delay, clock recovery, word assembly, fifo, alignment
`timescale 1ns/1ps
`include "bdr_regs.svh"

// small synchronous fifo with valid/ready on both sides
module bdr_fifo #(
    parameter int WIDTH = `BDR_WORD,
    parameter int DEPTH = `BDR_FIFO_DEPTH
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic doWr;
    logic doRd;

    assign inReady = (count_q != CW'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    // storage is not reset; only the pointers and the count carry state
    always_ff @(posedge ref_clk)
    begin
        if (doWr)
            mem[wrPtr_q] <= inData;
    end

    // pointers wrap at depth, count tracks occupancy
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (doWr)
                wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            if (doRd)
                rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            if (doWr && !doRd)
                count_q <= count_q + 1'b1;
            else if (doRd && !doWr)
                count_q <= count_q - 1'b1;
        end
    end
endmodule

module bdr_receiver
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire bdr_pkg::bdr_mode_e mode,
    bdr_link_if.rx link,
    input wire logic dlyLoad,
    input wire logic [`BDR_ALL_LINES*`BDR_DLY_W-1:0] dlyLoadVal,
    input wire logic dlyIncr,
    input wire logic dlyDecr,
    input wire logic [`BDR_SEL_W-1:0] dlySel,
    input wire logic [`BDR_NSRC-1:0] errClear,
    output logic [`BDR_NSRC*`BDR_WORD-1:0] outWords,
    output logic outValid,
    input wire logic outReady,
    output logic [`BDR_NSRC-1:0] parityErr,
    output logic [`BDR_NSRC-1:0] overflow
);
    import bdr_pkg::*;

    logic [`BDR_ALL_LINES-1:0] lineD;
    logic tick1_q;
    logic tick2_q;
    logic tick3_q;
    logic [`BDR_NSRC-1:0] fifoValid;
    logic [`BDR_NSRC*`BDR_WORD-1:0] fifoData;
    logic take;
    logic [`BDR_NSRC*`BDR_WORD-1:0] outWords_q;
    logic outValid_q;
    logic [`BDR_NSRC-1:0] perr_q;
    logic [`BDR_NSRC-1:0] ovf_q;

    // tick passes the synchroniser and the first history stage, like a line at tap zero;
    // one stage short, legacy words would be sampled a cycle early and long taps misframe
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            tick1_q <= 1'b0;
            tick2_q <= 1'b0;
            tick3_q <= 1'b0;
        end
        else
        begin
            tick1_q <= link.sysTick;
            tick2_q <= tick1_q;
            tick3_q <= tick2_q;
        end
    end

    genvar l;
    generate
        for (l = 0; l < `BDR_ALL_LINES; l = l + 1)
        begin : g_line
            logic s1_q;
            logic s2_q;
            logic [`BDR_HIST-1:0] hist_q;
            logic [`BDR_DLY_W-1:0] tap_q;

            // synchroniser then a delay line; the tap picks the delay in cycles
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    hist_q <= '0;
                end
                else
                begin
                    s1_q <= link.lines[l];
                    s2_q <= s1_q;
                    hist_q <= {hist_q[`BDR_HIST-2:0], s2_q};
                end
            end

            // steps saturate so a scan past the end cannot wrap the delay
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                    tap_q <= '0;
                else if (dlyLoad)
                    tap_q <= dlyLoadVal[l*`BDR_DLY_W +: `BDR_DLY_W];
                else if (dlySel == `BDR_SEL_W'(l))
                begin
                    if (dlyIncr && !dlyDecr && tap_q != `BDR_DLY_MAX)
                        tap_q <= tap_q + 1'b1;
                    else if (dlyDecr && !dlyIncr && tap_q != '0)
                        tap_q <= tap_q - 1'b1;
                end
            end
            assign lineD[l] = hist_q[tap_q];
        end
    endgenerate

    genvar s;
    generate
        for (s = 0; s < `BDR_NSRC; s = s + 1)
        begin : g_src
            logic [`BDR_NLINE-1:0] grp;
            logic clkPrev_q;
            logic rise;
            logic fall;
            logic [3:0] highCnt_q;
            logic armed_q;
            logic [1:0] slot_q;
            logic [1:0] slotNow;
            logic [`BDR_WORD-1:0] shift_q;
            logic par_q;
            logic [`BDR_WORD-1:0] word;
            logic push;
            logic err;
            logic inReady;

            assign grp = lineD[s*`BDR_NLINE +: `BDR_NLINE];
            // recovered clock of this source: edges of its own clock line
            assign rise = grp[`BDR_CLK_LINE] && !clkPrev_q;
            assign fall = !grp[`BDR_CLK_LINE] && clkPrev_q;
            assign slotNow = (rise && (armed_q || tick3_q)) ? 2'h0 : slot_q;

            // edge tracking, high-time measurement and word framing
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    clkPrev_q <= 1'b0;
                    highCnt_q <= 4'h0;
                    armed_q <= 1'b0;
                    slot_q <= 2'h0;
                    par_q <= 1'b0;
                end
                else
                begin
                    clkPrev_q <= grp[`BDR_CLK_LINE];
                    if (rise)
                        highCnt_q <= 4'h1;
                    else if (grp[`BDR_CLK_LINE] && highCnt_q != `BDR_HIGH_MAX)
                        highCnt_q <= highCnt_q + 4'h1;
                    if (rise)
                        armed_q <= 1'b0;
                    else if (tick3_q)
                        armed_q <= 1'b1;
                    if (rise || fall)
                        slot_q <= slotNow + 2'h1;
                    if (fall && slotNow == 2'h1)
                        par_q <= (highCnt_q > `BDR_HIGH_THR);
                end
            end

            // each edge deposits 24 bits; slot 0 sits in the low bits
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                    shift_q <= '0;
                else if (rise || fall)
                    shift_q[int'(slotNow)*`BDR_NDATA +: `BDR_NDATA] <=
                        grp[`BDR_NDATA-1:0];
            end

            // word completes on the last edge; legacy samples once per tick
            always_comb
            begin
                if (mode == BDR_LEGACY)
                begin
                    push = tick3_q;
                    word = {{(`BDR_WORD-`BDR_NDATA){1'b0}}, grp[`BDR_NDATA-1:0]};
                    err = ~^grp;
                end
                else
                begin
                    push = (rise || fall) && slotNow == 2'h3;
                    word = {grp[`BDR_NDATA-1:0], shift_q[3*`BDR_NDATA-1:0]};
                    err = ~^{word, par_q};
                end
            end

            // set beats clear so an error in the clearing cycle survives
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    perr_q[s] <= 1'b0;
                    ovf_q[s] <= 1'b0;
                end
                else
                begin
                    if (push && err)
                        perr_q[s] <= 1'b1;
                    else if (errClear[s])
                        perr_q[s] <= 1'b0;
                    if (push && !inReady)
                        ovf_q[s] <= 1'b1;
                    else if (errClear[s])
                        ovf_q[s] <= 1'b0;
                end
            end

            // the link cannot be paused, so a full fifo drops and flags the word
            bdr_fifo #(.WIDTH(`BDR_WORD), .DEPTH(`BDR_FIFO_DEPTH)) u_fifo (
                .ref_clk(ref_clk),
                .reset(reset),
                .inValid(push),
                .inReady(inReady),
                .inData(word),
                .outValid(fifoValid[s]),
                .outReady(take),
                .outData(fifoData[s*`BDR_WORD +: `BDR_WORD])
            );
        end
    endgenerate

    // pop every source at once, only when all hold a word
    assign take = (&fifoValid) && (!outValid_q || outReady);

    // output register with valid held until the consumer accepts
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            outWords_q <= '0;
            outValid_q <= 1'b0;
        end
        else if (take)
        begin
            outWords_q <= fifoData;
            outValid_q <= 1'b1;
        end
        else if (outReady)
            outValid_q <= 1'b0;
    end

    assign outWords = outWords_q;
    assign outValid = outValid_q;
    assign parityErr = perr_q;
    assign overflow = ovf_q;
endmodule

// ---- logic/bdr_regs.svh ----
// timing and geometry constants of the backplane ddr link
`ifndef BDR_REGS_SVH
`define BDR_REGS_SVH
`define BDR_NSRC 16
`define BDR_NLINE 25
`define BDR_NDATA 24
`define BDR_CLK_LINE 24
`define BDR_WORD 96
`define BDR_SLOTS 4
`define BDR_ALL_LINES 400
`define BDR_SEL_W 9
`define BDR_SYS_CYC 4'hF
`define BDR_FWD_HALF 4'h8
`define BDR_HIGH_P1 4'h5
`define BDR_HIGH_P0 4'h3
`define BDR_HIGH_THR 4'h4
`define BDR_HIGH_MAX 4'hF
`define BDR_DLY_W 3
`define BDR_DLY_MAX 3'h7
`define BDR_HIST 8
`define BDR_FIFO_DEPTH 4
`endif

// ---- logic/bdr_pkg.sv ----
// types shared by both ends of the backplane ddr link
package bdr_pkg;
    typedef enum logic {BDR_LEGACY, BDR_HIGHRATE} bdr_mode_e;
endpackage

// ---- logic/bdr_link_if.sv ----
// backplane lines between the module transmitters and the receiver
`timescale 1ns/1ps
`include "bdr_regs.svh"
interface bdr_link_if;
    logic [`BDR_ALL_LINES-1:0] lines; // 16 groups of 25 lines, line 24 of a group is clock/parity
    logic sysTick; // marks the start of each system cycle
    modport tx (output lines, output sysTick);
    modport rx (input lines, input sysTick);
endinterface

// ---- logic/bdr_transmitter.sv ----
// processor module end: drives legacy words or ddr data with duty-coded clock
`timescale 1ns/1ps
`include "bdr_regs.svh"
module bdr_transmitter
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire bdr_pkg::bdr_mode_e mode,
    bdr_link_if.tx link,
    input wire logic [`BDR_NSRC*`BDR_WORD-1:0] words,
    output logic wordTaken
);
    import bdr_pkg::*;

    logic [3:0] phase_q;
    logic tick_q;
    logic taken_q;
    logic [`BDR_ALL_LINES-1:0] lines_q;

    // system cycle divider; the forwarded clock is derived from it at twice its rate
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            phase_q <= 4'h0;
        else if (phase_q == `BDR_SYS_CYC)
            phase_q <= 4'h0;
        else
            phase_q <= phase_q + 4'h1;
    end

    // tick and word strobe change together with the first launch of a word
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            tick_q <= 1'b0;
            taken_q <= 1'b0;
        end
        else
        begin
            tick_q <= (phase_q == 4'h0);
            taken_q <= (phase_q == 4'h0);
        end
    end

    genvar s;
    generate
        for (s = 0; s < `BDR_NSRC; s = s + 1)
        begin : g_src
            logic [`BDR_WORD-1:0] hold_q;
            logic par_q;
            logic [`BDR_WORD-1:0] newWord;
            logic [3:0] highLen;
            assign newWord = words[s*`BDR_WORD +: `BDR_WORD];
            // duty cycle of the clock line carries the parity of the word
            assign highLen = par_q ? `BDR_HIGH_P1 : `BDR_HIGH_P0;

            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    hold_q <= '0;
                    par_q <= 1'b0;
                    lines_q[s*`BDR_NLINE +: `BDR_NLINE] <= '0;
                end
                else if (mode == BDR_LEGACY)
                begin
                    // one word plus odd parity held for the whole system cycle
                    if (phase_q == 4'h0)
                    begin
                        hold_q <= newWord;
                        lines_q[s*`BDR_NLINE +: `BDR_NLINE] <=
                            {~^newWord[`BDR_NDATA-1:0], newWord[`BDR_NDATA-1:0]};
                    end
                end
                else if (phase_q == 4'h0)
                begin
                    // rising edge and first slot leave in the same cycle
                    hold_q <= newWord;
                    par_q <= ~^newWord;
                    lines_q[s*`BDR_NLINE +: `BDR_NLINE] <=
                        {1'b1, newWord[0 +: `BDR_NDATA]};
                end
                else if (phase_q == highLen)
                    lines_q[s*`BDR_NLINE +: `BDR_NLINE] <=
                        {1'b0, hold_q[`BDR_NDATA +: `BDR_NDATA]};
                else if (phase_q == `BDR_FWD_HALF)
                    lines_q[s*`BDR_NLINE +: `BDR_NLINE] <=
                        {1'b1, hold_q[2*`BDR_NDATA +: `BDR_NDATA]};
                else if (phase_q == (`BDR_FWD_HALF + highLen))
                    lines_q[s*`BDR_NLINE +: `BDR_NLINE] <=
                        {1'b0, hold_q[3*`BDR_NDATA +: `BDR_NDATA]};
            end
        end
    endgenerate

    assign link.lines = lines_q;
    assign link.sysTick = tick_q;
    assign wordTaken = taken_q;
endmodule

// ---- testbench/bdr_link_monitor.sv ----
// assertions on the backplane lines joining transmitter and receiver
`timescale 1ns/1ps
`include "bdr_regs.svh"
module bdr_link_monitor
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire bdr_pkg::bdr_mode_e mode,
    input wire logic [`BDR_ALL_LINES-1:0] lines,
    input wire logic sysTick
);
    import bdr_pkg::*;
    logic [`BDR_NSRC-1:0] grpClk;
    logic [`BDR_NSRC-1:0] grpPar;
    logic hr;
    // clock line and whole-group parity of every source
    for (genvar s = 0; s < `BDR_NSRC; s++)
    begin : g_grp
        assign grpClk[s] = lines[s*`BDR_NLINE+`BDR_CLK_LINE];
        assign grpPar[s] = ^lines[s*`BDR_NLINE+:`BDR_NLINE];
    end
    assign hr = (mode == BDR_HIGHRATE);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_tick_period: assert property (sysTick |-> ##16 sysTick)
        else $error("system tick period wrong");
    a_tick_gap: assert property (sysTick |=> !sysTick [*8])
        else $error("system tick too long");
    a_legacy_hold: assert property (!hr && !sysTick |-> $stable(lines))
        else $error("legacy lines moved inside a cycle");
    a_legacy_parity: assert property (!hr && sysTick |-> &grpPar)
        else $error("legacy group parity not odd");
    // duty of one period is 3 or 5 cycles high out of 8
    a_clk_duty: assert property (hr && $rose(grpClk[0]) |->
        (grpClk[0] [*3] ##1 !grpClk[0] [*5] ##1 grpClk[0]) or
        (grpClk[0] [*5] ##1 !grpClk[0] [*3] ##1 grpClk[0]))
        else $error("forwarded clock duty wrong");
    a_rise_timing: assert property (hr && $rose(grpClk[0]) |->
        sysTick || $past(sysTick, 8))
        else $error("clock rise off the word grid");
    a_tick_clk: assert property (hr && sysTick |-> &grpClk)
        else $error("clock low at start of word");
    a_data_edge: assert property (hr && $stable(grpClk[0]) |->
        $stable(lines[`BDR_NDATA-1:0]))
        else $error("data moved between clock edges");
endmodule

// ---- testbench/backplane_ddr_receiver_tb.sv ----
// self-checking bench: transmitter and receiver joined over the backplane lines
`timescale 1ns/1ps
`include "bdr_regs.svh"
module backplane_ddr_receiver_tb;
    import bdr_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    bdr_mode_e mode = BDR_LEGACY;
    logic [`BDR_NSRC*`BDR_WORD-1:0] words;
    logic [`BDR_NSRC*`BDR_WORD-1:0] outWords;
    logic [`BDR_WORD-1:0] keep = '1;
    logic wordTaken, outValid;
    logic outReady = 1'b1;
    logic cmpOn = 1'b0;
    logic dlyLoad = 1'b0;
    logic dlyIncr = 1'b0;
    logic dlyDecr = 1'b0;
    logic [`BDR_ALL_LINES*`BDR_DLY_W-1:0] dlyLoadVal = '0;
    logic [`BDR_SEL_W-1:0] dlySel = '0;
    logic [`BDR_NSRC-1:0] errClear = '0;
    logic [`BDR_NSRC-1:0] parityErr, overflow, parityErr2;
    logic [3:0] kNext = 4'h0;
    logic [3:0] kGot, prevK;
    logic prevOk = 1'b0;
    int fail_count = 0;
    int compares = 0;
    int pops = 0;
    bdr_link_if bdr_link_if_i();
    bdr_link_if bdr_link_if_b_i();
    bdr_transmitter bdr_transmitter_i (.ref_clk(ref_clk), .reset(reset), .mode(mode),
        .link(bdr_link_if_i), .words(words), .wordTaken(wordTaken));
    bdr_receiver bdr_receiver_i (.ref_clk(ref_clk), .reset(reset), .mode(mode),
        .link(bdr_link_if_i), .dlyLoad(dlyLoad), .dlyLoadVal(dlyLoadVal), .dlyIncr(dlyIncr),
        .dlyDecr(dlyDecr), .dlySel(dlySel), .errClear(errClear), .outWords(outWords),
        .outValid(outValid), .outReady(outReady), .parityErr(parityErr), .overflow(overflow));
    // second receiver fed by the bench with faulty parity
    bdr_receiver bdr_receiver_b_i (.ref_clk(ref_clk), .reset(reset), .mode(BDR_LEGACY),
        .link(bdr_link_if_b_i), .dlyLoad(dlyLoad), .dlyLoadVal(dlyLoadVal), .dlyIncr(dlyIncr),
        .dlyDecr(dlyDecr), .dlySel(dlySel), .errClear(errClear), .outWords(),
        .outValid(), .outReady(1'b1), .parityErr(parityErr2), .overflow());
    bdr_link_monitor bdr_link_monitor_i (.ref_clk(ref_clk), .reset(reset), .mode(mode),
        .lines(bdr_link_if_i.lines), .sysTick(bdr_link_if_i.sysTick));
    always #5 ref_clk = ~ref_clk;
    // word pattern: take index sits in the low byte so legacy words carry it too
    function automatic logic [`BDR_WORD-1:0] mk(int s, logic [3:0] k);
        logic [3:0] s4;
        s4 = 4'(s);
        return {s4, k, 80'h0123456789ABCDEF0123, k, s4 ^ k};
    endfunction
    function automatic logic [`BDR_NSRC*`BDR_WORD-1:0] all(logic [3:0] k);
        logic [`BDR_NSRC*`BDR_WORD-1:0] v;
        for (int s = 0; s < `BDR_NSRC; s++)
            v[s*`BDR_WORD+:`BDR_WORD] = mk(s, k);
        return v;
    endfunction
    task automatic check(logic [`BDR_WORD-1:0] got, logic [`BDR_WORD-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic print_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // new pattern once the transmitter has taken a word
    always @(posedge ref_clk)
        if (wordTaken === 1'b1)
        begin
            kNext <= kNext + 4'h1;
            words <= all(kNext + 4'h1);
        end
    // popped words: every source from the same take, takes in unbroken order
    always @(posedge ref_clk)
        if (!reset && cmpOn && outValid === 1'b1 && outReady)
        begin
            kGot = outWords[7:4];
            for (int s = 0; s < `BDR_NSRC; s++)
                check(outWords[s*`BDR_WORD+:`BDR_WORD], mk(s, kGot) & keep);
            if (prevOk)
                check(96'(kGot), 96'(4'(prevK + 4'h1)));
            prevK <= kGot;
            prevOk <= 1'b1;
            pops++;
        end
        else if (!cmpOn)
            prevOk <= 1'b0;
    task automatic start(bdr_mode_e m);
        @(posedge ref_clk);
        reset <= 1'b1;
        cmpOn <= 1'b0;
        mode <= m;
        keep <= (m == BDR_LEGACY) ? 96'h0000000000000000FFFFFF : '1;
        cyc(6);
        reset <= 1'b0;
        cmpOn <= 1'b1;
    endtask
    // group 0 on the wire, sampled a little after each edge
    task automatic wire_check(int n);
        logic [`BDR_NLINE-1:0] g;
        logic [`BDR_WORD-1:0] w;
        int he;
        int sl;
        int t;
        repeat (n)
        begin
            t = 0;
            while (bdr_link_if_i.sysTick !== 1'b1 && t < 40)
            begin
                @(posedge ref_clk);
                #1;
                t++;
            end
            w = words[`BDR_WORD-1:0];
            he = (^w) ? 3 : 5;
            for (int i = 0; i < 16; i++)
            begin
                g = bdr_link_if_i.lines[`BDR_NLINE-1:0];
                sl = (i >= he) + (i >= 8) + (i >= 8 + he);
                if (mode == BDR_LEGACY)
                    check(96'(g), 96'({~^w[23:0], w[23:0]}));
                else
                    check(96'(g), 96'({sl[0] == 1'b0, w[sl*24+:24]}));
                @(posedge ref_clk);
                #1;
            end
        end
    endtask
    // bench frames on the second link, source 3 with even parity
    task automatic fault_frames();
        logic [`BDR_NDATA-1:0] d;
        for (int f = 0; f < 4; f++)
        begin
            @(posedge ref_clk);
            bdr_link_if_b_i.sysTick <= 1'b1;
            for (int s = 0; s < `BDR_NSRC; s++)
            begin
                d = 24'(mk(s, 4'(f)));
                bdr_link_if_b_i.lines[s*`BDR_NLINE+:`BDR_NLINE] <= {~^d ^ (s == 3), d};
            end
            @(posedge ref_clk);
            bdr_link_if_b_i.sysTick <= 1'b0;
            cyc(14);
        end
    endtask
    initial
    begin
        words = all(4'h0);
        bdr_link_if_b_i.lines = '0;
        bdr_link_if_b_i.sysTick = 1'b0;
        start(BDR_LEGACY);
        wire_check(2);
        fault_frames();
        cyc(40);
        check(96'(parityErr2), 96'(16'h0008));
        errClear <= 16'h0008;
        @(posedge ref_clk);
        errClear <= '0;
        cyc(2);
        check(96'(parityErr2), 96'(0));
        check(96'(parityErr), 96'(0));
        start(BDR_HIGHRATE);
        wire_check(3);
        cyc(64);
        // stall the output until every fifo refuses
        cmpOn <= 1'b0;
        outReady <= 1'b0;
        cyc(128);
        check(96'(overflow), 96'(16'hFFFF));
        outReady <= 1'b1;
        cyc(48);
        errClear <= '1;
        @(posedge ref_clk);
        errClear <= '0;
        cyc(2);
        check(96'(overflow), 96'(0));
        cmpOn <= 1'b1;
        cyc(64);
        // load all taps, then step source 0 one tap later while running
        cmpOn <= 1'b0;
        dlyLoadVal <= {`BDR_ALL_LINES{3'h2}};
        dlyLoad <= 1'b1;
        @(posedge ref_clk);
        dlyLoad <= 1'b0;
        for (int l = 0; l < `BDR_NLINE; l++)
        begin
            @(posedge ref_clk);
            dlySel <= 9'(l);
            dlyIncr <= 1'b1;
            @(posedge ref_clk);
            dlyIncr <= 1'b0;
        end
        cyc(64);
        // retuning taps under traffic garbles the words in flight; clear their flags
        errClear <= '1;
        @(posedge ref_clk);
        errClear <= '0;
        cmpOn <= 1'b1;
        cyc(96);
        check(96'(pops > 20), 96'(1));
        check(96'(parityErr), 96'(0));
        print_verdict();
    end
    // cut a hang short
    initial
    begin
        #100000;
        fail_count++;
        print_verdict();
    end
endmodule
